// ===== adc_conv_model.sv
`timescale 1ns/100ps
module adc_conv_model #(
  parameter int DLY = 3
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Start request from the block
  input  wire logic        start_i,
  input  wire logic [3:0]  chan_i,
  // Result back to the block
  output logic             done_o,
  output logic      [15:0] data_o
);
  logic [3:0] cnt;
  logic [3:0] chan_q;
  logic [7:0] seq;

  // --------------------------------------------------------------
  // Conversion timer: result appears DLY cycles after each start
  // --------------------------------------------------------------
  // Data toggles outside the done cycle so a stale byte never matches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt    <= 4'h0;
      seq    <= 8'h00;
      done_o <= 1'b0;
      data_o <= 16'h5A5A;
    end else begin
      done_o <= (cnt == 4'h1);
      data_o <= (cnt == 4'h1) ? {seq, 4'hA, chan_q} : ~data_o;
      seq    <= seq + {7'h00, cnt == 4'h1};
      if (start_i) begin
        cnt    <= 4'(DLY);
        chan_q <= chan_i;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule // adc_conv_model

// ===== adc_scan_fifo_control.sv
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
// Contract
// - Hardware trigger disabled: only a software start write begins a conversion.
// - Hardware trigger, source 0: each external rising edge triggers.
// - Hardware trigger, source 1: counter/timer 0 output paces conversions.
// - Every result goes to FIFO as two bytes, low then high.
// - Host reads offset 0 then 1; each read pops next byte.
// - Scan mode converts low channel through high channel per trigger.
// - Single mode: one conversion, step channel, wait for next trigger.
// - After high channel the channel counter returns to low channel.
// - Scan starts spaced 5 us, or 9.3 us when interval bit set.
// - FIFO interrupt mode withholds request until occupancy reaches threshold.
// - Order: trigger, conversion, FIFO store, interrupt; host drains and clears.
// - FIFO holds 4096 bytes, 2048 samples.
// - Empty flag is 1 exactly when FIFO holds no data.
// - Eighth-full flag is 1 at 256 or more samples.
// - Half-full flag is 1 at 2048 or more bytes.
// - Full flag is 1 exactly at 4096 bytes.
// - Result arriving when full sets overrun, is dropped, contents kept.
// - Overrun clears only by FIFO reset bit in command register.
// - Channel register: low nibble low, high nibble high; write loads current.
// - Busy is status bit 7: settling, converting or scanning.
// - Interrupt only while enabled; timing from irq mode, level, scan.

module adc_scan_fifo_control #(
  parameter int FIFO_BYTES = adc_scan_pkg::FIFO_BYTES_DEF
) (
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:2]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Trigger sources
  input  wire logic        ext_trigger_in_i,
  input  wire logic        timer0_out_i,
  // Converter and input multiplexer
  output logic             conv_start_o,
  output logic      [3:0]  conv_chan_o,
  input  wire logic        conv_done_i,
  input  wire logic [15:0] conv_data_i,
  // Interrupt request
  output logic             conv_irq_o
);
  import adc_scan_pkg::*;

  localparam int AW = $clog2(FIFO_BYTES);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Byte pairing and level compares need a power of two above half level
  if ((FIFO_BYTES != (1 << AW)) || (FIFO_BYTES <= HALF_BYTES)) begin : g_bad_depth
    $error("FIFO_BYTES must be a power of two above the half-full level");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_type        state;
  state_type        next_state;
  logic [TMR_W-1:0] tmr;
  logic [TMR_W-1:0] next_tmr;
  logic [3:0]       cur_chan;
  logic [3:0]       next_cur;
  logic [15:0]      result;
  logic [15:0]      next_result;
  logic             ovf;
  logic             next_ovf;
  logic             irq_pend;
  logic             next_pend;
  logic [7:0]       chan_reg;
  mode_type         mode;
  logic             ack;

  logic [7:0]       mem [FIFO_BYTES];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;

  logic             ext_meta;
  logic             ext_s2;
  logic             ext_s3;
  logic             ext_lvl;
  logic             tmr0_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One access per ack; the request is not taken again in the ack cycle
  wire        take      = cyc_i & stb_i & ~ack;
  wire        wr        = take & we_i & sel_i[0];
  wire        rd        = take & ~we_i;
  wire        sel_lo    = (adr_i == IDX_FIFO_LO);
  wire        sel_hi    = (adr_i == IDX_FIFO_HI);
  wire        wr_chan   = wr & (adr_i == IDX_CHAN);
  wire        wr_cmd    = wr & (adr_i == IDX_CMD);
  wire        wr_mode   = wr & (adr_i == IDX_MODE);
  wire        sw_start  = wr_cmd & dat_i[CMD_START_BIT];
  wire        fifo_clear = wr_cmd & dat_i[CMD_FCLR_BIT];
  wire        irq_clear = wr_cmd & dat_i[CMD_IRQCLR_BIT];

  // ----------------------------------------------------------------
  // FIFO levels
  // ----------------------------------------------------------------
  // Levels count bytes, so a half-read sample still counts as one byte
  wire        empty     = (count == '0);
  wire        eighth    = 32'(count) >= EIGHTH_BYTES;
  wire        half      = 32'(count) >= HALF_BYTES;
  wire        full      = 32'(count) == FIFO_BYTES;
  // A sample needs two free bytes; a half-read sample may leave one
  wire        room      = 32'(count) <= (FIFO_BYTES - 2);
  wire        pop       = rd & (sel_lo | sel_hi) & ~empty;
  wire        push      = (state == ST_STORE_LO) | (state == ST_STORE_HI);
  wire [7:0]  push_byte = (state == ST_STORE_LO) ? result[7:0] : result[15:8];
  wire [AW-1:0] samples = AW'(count >> 1);
  wire        at_level  = mode.fifo_level_select ?
                          (32'(samples) >= LOW_TH_SAMPLES) :
                          (32'(samples) >= HIGH_TH_SAMPLES);

  // ----------------------------------------------------------------
  // Status and read mux
  // ----------------------------------------------------------------
  // Busy covers settling, conversion, storing and the scan gap
  status_type status;
  assign status.converter_busy_flag = (state != ST_IDLE);
  assign status.reserved            = 1'b0;
  assign status.irq_pending         = irq_pend;
  assign status.fifo_overrun_flag   = ovf;
  assign status.fifo_full_flag      = full;
  assign status.half_full_flag      = half;
  assign status.eighth_full_flag    = eighth;
  assign status.fifo_empty_flag     = empty;

  // Reading an empty FIFO returns whatever the cell holds
  wire [7:0] rd_byte =
    (sel_lo | sel_hi)        ? mem[rptr] :
    (adr_i == IDX_CHAN)      ? chan_reg :
    (adr_i == IDX_CMD)       ? {4'h0, cur_chan} :
    (adr_i == IDX_STATUS)    ? status :
    (adr_i == IDX_MODE)      ? mode :
                               8'h00;

  // ----------------------------------------------------------------
  // Trigger selection
  // ----------------------------------------------------------------
  // Edge counts only once the second and third stages agree
  wire ext_rise  = ext_s2 & ext_s3 & ~ext_lvl;
  wire tmr0_rise = timer0_out_i & ~tmr0_q;
  wire hw_rise   = mode.hw_trigger_source ? tmr0_rise : ext_rise;
  wire trig      = mode.hw_trigger_enable ? hw_rise : sw_start;

  // ----------------------------------------------------------------
  // Channel stepping and scan timing
  // ----------------------------------------------------------------
  wire [3:0]  low_chan  = chan_reg[3:0];
  wire [3:0]  high_chan = chan_reg[7:4];
  wire        last      = (cur_chan == high_chan);
  wire [TMR_W-1:0] interval =
    mode.scan_interval_select ? SCAN_SLOW_CYC : SCAN_FAST_CYC;
  wire        tmr_sat   = &tmr;

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  // Triggers that arrive while busy are ignored, not queued
  always_comb begin
    next_state  = state;
    next_tmr    = tmr_sat ? tmr : tmr + 1'b1;
    next_cur    = cur_chan;
    next_result = result;
    next_ovf    = ovf & ~fifo_clear;
    next_pend   = irq_pend & ~irq_clear;
    case (state)
      ST_IDLE: begin
        if (trig) begin
          if (mode.multi_channel_scan) begin
            next_cur = low_chan;
          end
          next_state = ST_START;
        end
      end
      ST_SETTLE: begin
        if (tmr >= SETTLE_CYC - 1'b1) begin
          next_state = ST_IDLE;
        end
      end
      ST_START: begin
        // Timer now measures from this start for the scan spacing
        next_tmr   = TMR_W'(1);
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (conv_done_i) begin
          next_result = conv_data_i;
          if (room) begin
            next_state = ST_STORE_LO;
          end else begin
            next_ovf   = 1'b1;
            next_state = ST_STEP;
          end
        end
      end
      ST_STORE_LO: begin
        // A clear between the two bytes drops the high byte too
        next_state = fifo_clear ? ST_STEP : ST_STORE_HI;
      end
      ST_STORE_HI: begin
        next_state = ST_STEP;
      end
      ST_STEP: begin
        next_cur = last ? low_chan : cur_chan + 1'b1;
        if (mode.multi_channel_scan && !last) begin
          next_state = ST_GAP;
        end else begin
          next_state = ST_IDLE;
          if (mode.conv_irq_enable &&
              (!mode.fifo_irq_mode || at_level)) begin
            next_pend = 1'b1;
          end
        end
      end
      ST_GAP: begin
        if (tmr >= interval - 1'b1) begin
          next_state = ST_START;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // A channel write reloads and restarts settling from any state
    if (wr_chan) begin
      next_cur   = dat_i[3:0];
      next_tmr   = '0;
      next_state = ST_SETTLE;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  // All sequencer state freezes while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= ST_IDLE;
      tmr      <= '0;
      cur_chan <= 4'h0;
      result   <= 16'h0000;
      ovf      <= 1'b0;
      irq_pend <= 1'b0;
    end else if (ce_i) begin
      state    <= next_state;
      tmr      <= next_tmr;
      cur_chan <= next_cur;
      result   <= next_result;
      ovf      <= next_ovf;
      irq_pend <= next_pend;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Mode bit 7 is reserved and always stored as 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_reg <= CHAN_RESET;
      mode     <= MODE_RESET;
    end else if (ce_i) begin
      if (wr_chan) begin
        chan_reg <= dat_i[7:0];
      end
      if (wr_mode) begin
        mode <= {1'b0, dat_i[6:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // FIFO pointers and count
  // ----------------------------------------------------------------
  // Clear wins over a push or pop in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else if (ce_i) begin
      if (fifo_clear) begin
        wptr  <= '0;
        rptr  <= '0;
        count <= '0;
      end else begin
        if (push) begin
          wptr <= wptr + 1'b1;
        end
        if (pop) begin
          rptr <= rptr + 1'b1;
        end
        if (push && !pop) begin
          count <= count + 1'b1;
        end else if (pop && !push) begin
          count <= count - 1'b1;
        end
      end
    end
  end

  // FIFO storage, no reset so it maps onto block memory
  always_ff @(posedge clk_i) begin
    if (ce_i && push && !fifo_clear) begin
      mem[wptr] <= push_byte;
    end
  end

  // ----------------------------------------------------------------
  // Trigger input conditioning
  // ----------------------------------------------------------------
  // Three stages on the pin; the timer output shares the clock and needs none
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_meta <= 1'b0;
      ext_s2   <= 1'b0;
      ext_s3   <= 1'b0;
      ext_lvl  <= 1'b0;
      tmr0_q   <= 1'b0;
    end else if (ce_i) begin
      ext_meta <= ext_trigger_in_i;
      ext_s2   <= ext_meta;
      ext_s3   <= ext_s2;
      if (ext_s2 == ext_s3) begin
        ext_lvl <= ext_s3;
      end
      tmr0_q   <= timer0_out_i;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Ack lasts one cycle; read data is captured at the take
  // Start and channel come from next values so they line up with the state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack          <= 1'b0;
      dat_o        <= 32'h0000_0000;
      conv_start_o <= 1'b0;
      conv_chan_o  <= 4'h0;
      conv_irq_o   <= 1'b0;
    end else if (ce_i) begin
      ack          <= take;
      if (rd) begin
        dat_o <= {24'h00_0000, rd_byte};
      end
      conv_start_o <= (next_state == ST_START);
      conv_chan_o  <= next_cur;
      conv_irq_o   <= next_pend & mode.conv_irq_enable;
    end
  end

  assign ack_o = ack;

endmodule // adc_scan_fifo_control

// ===== adc_scan_fifo_control_tb.sv
`timescale 1ns/100ps
module adc_scan_fifo_control_tb;
  import adc_scan_pkg::*;

  // --------------------------------------------------------------
  // Signals and counters
  // --------------------------------------------------------------
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic        ext_trigger_in_i = 1'b0, timer0_out_i = 1'b0, conv_done_i, ack_o, conv_start_o, conv_irq_o;
  logic [3:0]  adr_i = 4'h0, sel_i = 4'h0, conv_chan_o;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [15:0] conv_data_i;
  int          mismatches = 0, compares = 0, cycles = 0, nstart = 0, last_start = 0, gap = 0;

  always #12.5 clk_i = ~clk_i;

  // Start spacing and a ceiling well above the ~36k cycles of the run
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (conv_start_o === 1'b1) begin
      gap        <= cycles - last_start;
      last_start <= cycles;
      nstart     <= nstart + 1;
    end
    if (cycles == 80000) begin
      mismatches++;
      end_sim();
    end
  end

  adc_scan_fifo_control i_adc_scan_fifo_control (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ext_trigger_in_i(ext_trigger_in_i),
    .timer0_out_i(timer0_out_i), .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .conv_irq_o(conv_irq_o));

  adc_conv_model i_adc_conv_model (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(conv_start_o), .chan_i(conv_chan_o),
    .done_o(conv_done_i), .data_o(conv_data_i));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic cycle: request held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= {3'h0, w};
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o[7:0];
    chk(16'(ack_o), 16'h1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    wb(1'b0, a, 8'h00, q);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  // Poll busy; settling alone takes some 400 cycles
  task automatic wait_idle();
    logic [7:0] q;
    int n;
    n = 0;
    do begin
      rd(IDX_STATUS, q);
      n++;
    end while (q[7] !== 1'b0 && n < 500);
    chk(16'(q[7]), 16'h0);
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      timer0_out_i <= 1'b1;
      @(posedge clk_i);
      timer0_out_i <= 1'b0;
      repeat (14) @(posedge clk_i);
    end
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] q;
    rd(IDX_STATUS, q);
    chk(16'(q), 16'h01);
    rd(IDX_MODE, q);
    chk(16'(q), 16'(MODE_RESET));
    rd(4'h5, q);
    chk(16'(q), 16'h00);
    rd(IDX_FIFO_LO, q);
    rd(IDX_STATUS, q);
    chk(16'(q), 16'h01);
  endtask

  // Channels 1..2 in single mode: step and wrap on each strobe
  task automatic t_single();
    logic [7:0] q;
    wr(IDX_CHAN, 8'h21);
    repeat (2) @(posedge clk_i);
    chk(16'(conv_chan_o), 16'h1);
    rd(IDX_STATUS, q);
    chk(16'(q), 16'h81);
    wait_idle();
    for (int i = 0; i < 3; i++) begin
      wr(IDX_CMD, 8'h01);
      wait_idle();
      rd(IDX_FIFO_LO, q);
      chk(16'(q), 16'(8'hA1 + 8'(i % 2)));
      rd(IDX_FIFO_HI, q);
      chk(16'(q), 16'(i));
      chk(16'(conv_chan_o), 16'(2 - (i % 2)));
    end
    chk(16'(conv_irq_o), 16'h0);
  endtask

  // Strobe ignored under hardware trigger; external edge starts one
  task automatic t_trigger();
    logic [7:0] q;
    int n0;
    wr(IDX_MODE, 8'h01);
    n0 = nstart;
    wr(IDX_CMD, 8'h01);
    repeat (20) @(posedge clk_i);
    chk(16'(nstart - n0), 16'h0);
    ext_trigger_in_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    ext_trigger_in_i <= 1'b0;
    wait_idle();
    chk(16'(nstart - n0), 16'h1);
    rd(IDX_FIFO_LO, q);
    chk(16'(q), 16'hA2);
    rd(IDX_FIFO_HI, q);
  endtask

  task automatic t_scan(input logic slow, input int spacing);
    logic [7:0] q;
    int n0;
    wr(IDX_MODE, {4'b0001, slow, 3'b100});
    wr(IDX_CHAN, 8'h31);
    wait_idle();
    n0 = nstart;
    wr(IDX_CMD, 8'h01);
    wait_idle();
    chk(16'(nstart - n0), 16'h3);
    chk(16'(gap), 16'(spacing));
    chk(16'(conv_irq_o), 16'h1);
    wr(IDX_CMD, 8'h04);
    chk(16'(conv_irq_o), 16'h0);
    for (int i = 0; i < 3; i++) begin
      rd(IDX_FIFO_LO, q);
      chk(16'(q), 16'(8'hA1 + 8'(i)));
      rd(IDX_FIFO_HI, q);
    end
  endtask

  // Timer-paced fill through every level, then overrun and reset
  task automatic t_fill();
    logic [7:0] q;
    wr(IDX_CMD, 8'h06);
    wr(IDX_MODE, 8'h00);
    wr(IDX_CHAN, 8'h00);
    wait_idle();
    wr(IDX_MODE, 8'h73);
    pulses(255);
    rd(IDX_STATUS, q);
    chk(16'({q[1], conv_irq_o}), 16'h0);
    pulses(1);
    rd(IDX_STATUS, q);
    chk(16'({q[1], conv_irq_o}), 16'h3);
    wr(IDX_CMD, 8'h04);
    wr(IDX_MODE, 8'h33);
    pulses(767);
    rd(IDX_STATUS, q);
    chk(16'({q[2], conv_irq_o}), 16'h0);
    pulses(1);
    rd(IDX_STATUS, q);
    chk(16'({q[2], conv_irq_o}), 16'h3);
    pulses(1023);
    rd(IDX_STATUS, q);
    chk(16'(q[4:3]), 16'h0);
    pulses(1);
    rd(IDX_STATUS, q);
    chk(16'(q[4:3]), 16'h1);
    pulses(1);
    rd(IDX_STATUS, q);
    chk(16'(q[4:3]), 16'h3);
    wr(IDX_MODE, 8'h00);
    rd(IDX_FIFO_LO, q);
    chk(16'(q), 16'hA0);
    rd(IDX_STATUS, q);
    chk(16'(q[4:3]), 16'h2);
    wr(IDX_CMD, 8'h02);
    rd(IDX_STATUS, q);
    chk(16'(q & 8'hDF), 16'h01);
    wr(IDX_CMD, 8'h04);
    repeat (2) @(posedge clk_i);
    chk(16'(conv_irq_o), 16'h0);
    rd(IDX_STATUS, q);
    chk(16'(q), 16'h01);
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_single();
    t_trigger();
    t_scan(1'b0, 200);
    t_scan(1'b1, 372);
    t_fill();
    end_sim();
  end
endmodule // adc_scan_fifo_control_tb

// ===== adc_scan_monitor.sv
`timescale 1ns/100ps
module adc_scan_monitor #(
  parameter int FIFO_BYTES = adc_scan_pkg::FIFO_BYTES_DEF
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Register bus
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:2]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_o,
  // Triggers, converter and interrupt
  input  wire logic        ext_trigger_in_i,
  input  wire logic        timer0_out_i,
  input  wire logic        conv_start_o,
  input  wire logic [3:0]  conv_chan_o,
  input  wire logic        conv_irq_o
);
  import adc_scan_pkg::*;

  // --------------------------------------------------------------
  // Shadow of the mode register and ages of trigger edges
  // --------------------------------------------------------------
  logic       take, wr_ok, mode_wr, chan_wr, start_wr, ext_d, tmr_d;
  logic [3:0] low_q, ext_age, tmr_age;
  mode_type   mode_q;

  // A request is taken only while ack is low
  assign take     = cyc_i & stb_i & ~ack_o & ce_i;
  assign wr_ok    = take & we_i & sel_i[0];
  assign mode_wr  = wr_ok & (adr_i == IDX_MODE);
  assign chan_wr  = wr_ok & (adr_i == IDX_CHAN);
  assign start_wr = wr_ok & (adr_i == IDX_CMD) & dat_i[CMD_START_BIT];

  // Ages saturate at 15 so an old edge never looks recent
  always_ff @(posedge clk_i) begin
    ext_d <= ext_trigger_in_i;
    tmr_d <= timer0_out_i;
    if (chan_wr) begin
      low_q <= dat_i[3:0];
    end
    if (rst_i) begin
      mode_q  <= mode_type'(MODE_RESET);
      ext_age <= 4'hF;
      tmr_age <= 4'hF;
    end else begin
      if (mode_wr) begin
        mode_q <= mode_type'(dat_i[7:0]);
      end
      ext_age <= (ext_trigger_in_i & ~ext_d) ? 4'h0 : ext_age + {3'h0, ext_age != 4'hF};
      tmr_age <= (timer0_out_i & ~tmr_d) ? 4'h0 : tmr_age + {3'h0, tmr_age != 4'hF};
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_reply_a: assert property (take |=> ack_o)
    else $error("Ack did not follow a taken request");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("Ack held longer than one cycle");
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !ack_o && !conv_start_o && !conv_irq_o)
    else $error("Outputs active just after reset");
  sw_start_a: assert property (conv_start_o && !mode_q.hw_trigger_enable && !mode_q.multi_channel_scan
    |-> $past(start_wr))
    else $error("Start without a software strobe");
  ext_start_a: assert property (conv_start_o && mode_q.hw_trigger_enable && !mode_q.hw_trigger_source
    && !mode_q.multi_channel_scan |-> ext_age inside {[2:8]})
    else $error("Start without a recent external edge");
  timer_start_a: assert property (conv_start_o && mode_q.hw_trigger_enable && mode_q.hw_trigger_source
    && !mode_q.multi_channel_scan |-> tmr_age <= 4'h3)
    else $error("Start without a recent timer edge");
  start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
    else $error("Start pulse longer than one cycle");
  irq_enable_a: assert property (conv_irq_o |-> $past(mode_q.conv_irq_enable))
    else $error("Interrupt while disabled");
  chan_load_a: assert property (chan_wr |-> ##[1:2] conv_chan_o == low_q)
    else $error("Channel write did not load low channel");
endmodule // adc_scan_monitor

bind adc_scan_fifo_control adc_scan_monitor #(.FIFO_BYTES(FIFO_BYTES)) i_adc_scan_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .ext_trigger_in_i(ext_trigger_in_i),
  .timer0_out_i(timer0_out_i), .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o), .conv_irq_o(conv_irq_o));

// ===== adc_scan_pkg.sv
package adc_scan_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_FIFO_LO = 4'h0;
  localparam logic [3:0] IDX_FIFO_HI = 4'h1;
  localparam logic [3:0] IDX_CHAN    = 4'h2;
  localparam logic [3:0] IDX_CMD     = 4'h8;
  localparam logic [3:0] IDX_STATUS  = 4'h9;
  localparam logic [3:0] IDX_MODE    = 4'hA;

  // Command register strobe bits (write only, self clearing)
  localparam int CMD_START_BIT  = 0;
  localparam int CMD_FCLR_BIT   = 1;
  localparam int CMD_IRQCLR_BIT = 2;

  // Reset values
  localparam logic [7:0] CHAN_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic reserved;
    logic fifo_level_select;
    logic fifo_irq_mode;
    logic conv_irq_enable;
    logic scan_interval_select;
    logic multi_channel_scan;
    logic hw_trigger_source;
    logic hw_trigger_enable;
  } mode_type;

  typedef struct packed {
    logic converter_busy_flag;
    logic reserved;
    logic irq_pending;
    logic fifo_overrun_flag;
    logic fifo_full_flag;
    logic half_full_flag;
    logic eighth_full_flag;
    logic fifo_empty_flag;
  } status_type;

  // ----------------------------------------------------------------
  // FIFO sizing and levels, in bytes and samples
  // ----------------------------------------------------------------
  localparam int FIFO_BYTES_DEF   = 4096;
  localparam int EIGHTH_BYTES     = 512;
  localparam int HALF_BYTES       = 2048;
  localparam int LOW_TH_SAMPLES   = 256;
  localparam int HIGH_TH_SAMPLES  = 1024;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 25;
  localparam int SETTLE_TIME_NS = 10000;
  localparam int SCAN_FAST_NS   = 5000;
  localparam int SCAN_SLOW_NS   = 9300;
  localparam int TMR_W          = 10;
  localparam logic [TMR_W-1:0] SETTLE_CYC =
    TMR_W'((SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] SCAN_FAST_CYC =
    TMR_W'((SCAN_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] SCAN_SLOW_CYC =
    TMR_W'((SCAN_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,
    ST_SETTLE   = 8'h02,
    ST_START    = 8'h04,
    ST_WAIT     = 8'h08,
    ST_STORE_LO = 8'h10,
    ST_STORE_HI = 8'h20,
    ST_STEP     = 8'h40,
    ST_GAP      = 8'h80
  } state_type;

endpackage
